// file: design/ffc_pkg.sv
/*
  Constants, state encodings and the two number-format conversion functions of the
  floating-point format converter. Assumes a single 100 MHz clock and no software access.
*/
// Behaviour
// - Direction high: convert memory-side IEEE word to native, drive host side.
// - Direction low: convert host-side native word to IEEE, drive memory side.
// - Drive enable deasserted: both buses released, nothing driven.
// - Non-pipelined reads and writes raise access-extend so the host waits.
// - Pipeline mode keeps access-extend low always.
// - Pipeline select high means pipeline mode; board ties it low otherwise.
// - Wait-state logic and pipeline register run on the one host phase clock.
// - A converted IEEE not-a-number pulses the interrupt low for 1.5 cycles; the code rounds this up and holds it low 2 cycles.
// - Two 32-bit two-way buses, host side and memory side.
// - Reset returns all logic, pipeline and wait state included, to idle.
// - In instruction-register pause, parity output shows even parity of instruction.
// - IEEE exponent 255 is special; nonzero fraction means not-a-number.
// - IEEE zero exponent means denormal mantissa without implied one.
// - Too-small denormals go to zero, error below 2^-127.
// - IEEE is signed magnitude, biased exponent; native is two's complement.
// - Pipeline output lags input one access; host flushes with one extra access.
// - Non-pipelined mode inserts exactly one wait state per access.
// - IEEE word: sign bit 31, exponent 30..23, fraction 22..0.
// - Native word: exponent 31..24, sign bit 23, fraction 22..0.
package ffc_pkg;
  localparam int DATA_W = 32;
  localparam int IR_W = 4;
  localparam int IEEE_SIGN_BIT = 31;
  localparam int IEEE_EXP_HI = 30;
  localparam int IEEE_EXP_LO = 23;
  localparam int NAT_EXP_HI = 31;
  localparam int NAT_EXP_LO = 24;
  localparam int NAT_SIGN_BIT = 23;
  localparam int FRAC_HI = 22;
  localparam logic [7:0] IEEE_EXP_SPECIAL = 8'hff;
  localparam logic [7:0] IEEE_EXP_MAX_FINITE = 8'hfe;
  localparam logic signed [9:0] IEEE_BIAS = 10'sh07f;
  localparam logic [7:0] NAT_ZERO_EXP = 8'h80;
  localparam logic signed [9:0] NAT_EXP_MAX = 10'sh07f;
  localparam logic signed [9:0] NAT_EXP_MIN = -10'sh07f;
  localparam int NAN_PULSE_HALF_CYCLES = 3;
  localparam int NAN_PULSE_CYCLES = (NAN_PULSE_HALF_CYCLES + 1) / 2;
  localparam int WAIT_STATES = 1;
  localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 4'h1;
  localparam logic [IR_W-1:0] IR_RESET_VAL = 4'hf;

  typedef enum logic [2:0] {A_IDLE = 3'b001, A_WAIT = 3'b010, A_HOLD = 3'b100} ffc_acc_e;

  typedef enum logic [15:0] {
    T_TLR = 16'h0001, T_RTI = 16'h0002, T_SDS = 16'h0004, T_CDR = 16'h0008,
    T_SDR = 16'h0010, T_E1D = 16'h0020, T_PDR = 16'h0040, T_E2D = 16'h0080,
    T_UDR = 16'h0100, T_SIS = 16'h0200, T_CIR = 16'h0400, T_SIR = 16'h0800,
    T_E1I = 16'h1000, T_PIR = 16'h2000, T_E2I = 16'h4000, T_UIR = 16'h8000
  } ffc_tap_e;

  function automatic ffc_tap_e ffc_tap_next(input ffc_tap_e st, input logic tms);
    case (st)
      T_TLR: ffc_tap_next = tms ? T_TLR : T_RTI;
      T_RTI, T_UDR, T_UIR: ffc_tap_next = tms ? T_SDS : T_RTI;
      T_SDS: ffc_tap_next = tms ? T_SIS : T_CDR;
      T_CDR, T_SDR: ffc_tap_next = tms ? T_E1D : T_SDR;
      T_E1D, T_E2D: ffc_tap_next = tms ? T_UDR : (st == T_E1D ? T_PDR : T_SDR);
      T_PDR: ffc_tap_next = tms ? T_E2D : T_PDR;
      T_SIS: ffc_tap_next = tms ? T_TLR : T_CIR;
      T_CIR, T_SIR: ffc_tap_next = tms ? T_E1I : T_SIR;
      T_E1I, T_E2I: ffc_tap_next = tms ? T_UIR : (st == T_E1I ? T_PIR : T_SIR);
      T_PIR: ffc_tap_next = tms ? T_E2I : T_PIR;
      default: ffc_tap_next = T_TLR;
    endcase
  endfunction : ffc_tap_next

  // IEEE single to native. Infinity and not-a-number saturate to the largest magnitude.
  function automatic logic [31:0] ffc_ieee_to_native(input logic [31:0] w);
    logic s;
    logic [7:0] be;
    logic [22:0] m;
    logic signed [9:0] e;
    logic signed [9:0] em1;
    logic zero;
    s = w[IEEE_SIGN_BIT];
    be = w[IEEE_EXP_HI:IEEE_EXP_LO];
    m = w[FRAC_HI:0];
    zero = 1'b0;
    e = $signed({2'b00, be}) - IEEE_BIAS;
    if (be == IEEE_EXP_SPECIAL)
    begin
      e = NAT_EXP_MAX;
      m = 23'h7fffff;
    end
    else if (be == 8'h00)
    begin
      // Only a denormal with its top fraction bit set reaches 2^-127; the rest go to zero.
      if (w[FRAC_HI])
      begin
        e = NAT_EXP_MIN;
        m = {w[21:0], 1'b0};
      end
      else
        zero = 1'b1;
    end
    em1 = e - 10'sh001;
    if (zero)
      ffc_ieee_to_native = {NAT_ZERO_EXP, 24'h000000};
    else if (!s)
      ffc_ieee_to_native = {e[7:0], 1'b0, m};
    else if (m != 23'h000000)
      ffc_ieee_to_native = {e[7:0], 1'b1, 23'(~m + 23'h000001)};
    else if (e == NAT_EXP_MIN)
      ffc_ieee_to_native = {e[7:0], 1'b1, 23'h7fffff};
    else
      ffc_ieee_to_native = {em1[7:0], 1'b1, 23'h000000};
  endfunction : ffc_ieee_to_native

  // Native to IEEE single. Values past the IEEE range saturate to the largest finite one.
  function automatic logic [31:0] ffc_native_to_ieee(input logic [31:0] w);
    logic s;
    logic [7:0] e8;
    logic [22:0] g;
    logic signed [9:0] be;
    s = w[NAT_SIGN_BIT];
    e8 = w[NAT_EXP_HI:NAT_EXP_LO];
    g = w[FRAC_HI:0];
    be = $signed({{2{e8[7]}}, e8}) + IEEE_BIAS;
    if (s && g == 23'h000000)
      be = be + 10'sh001;
    else if (s)
      g = 23'(~g + 23'h000001);
    if (e8 == NAT_ZERO_EXP)
      ffc_native_to_ieee = 32'h00000000;
    else if (be > $signed({2'b00, IEEE_EXP_MAX_FINITE}))
      ffc_native_to_ieee = {s, IEEE_EXP_MAX_FINITE, 23'h7fffff};
    else if (be <= 10'sh000)
      ffc_native_to_ieee = {s, 8'h00, 1'b1, g[22:1]};
    else
      ffc_native_to_ieee = {s, be[7:0], g};
  endfunction : ffc_native_to_ieee
endpackage : ffc_pkg

// file: design/ffc_top.sv
/*
  Floating-point format converter: a transceiver between host and IEEE memory that
  converts each word, adds a wait state or pipelines, flags not-a-number and carries
  a small test access port. Assumes all inputs synchronous to clk_i and the host
  holding drive_en_n_i low for the whole of an access.
*/
`timescale 1ns/1ns
module ffc_top #(
  parameter int IR_LEN = ffc_pkg::IR_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Access control
  input wire logic dir_i,
  input wire logic drive_en_n_i,
  input wire logic pipe_i,
  output logic access_extend_o,
  output logic invalid_number_irq_n_o,
  // Host side bus
  input wire logic [ffc_pkg::DATA_W-1:0] host_side_bus_i,
  output logic [ffc_pkg::DATA_W-1:0] host_side_bus_o,
  output logic host_side_bus_oe_o,
  // Memory side bus
  input wire logic [ffc_pkg::DATA_W-1:0] memory_side_bus_i,
  output logic [ffc_pkg::DATA_W-1:0] memory_side_bus_o,
  output logic memory_side_bus_oe_o,
  // Scan port
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic scan_instruction_parity_o
);
  import ffc_pkg::*;

  // Only the four-bit instruction register is built, so other lengths are refused.
  if (IR_LEN != IR_W)
  begin : g_ir_len_bad
    $error("IR_LEN must equal the package instruction width");
  end

  typedef struct packed {
    ffc_acc_e acc;
    logic extend;
    logic host_oe;
    logic mem_oe;
    logic [DATA_W-1:0] host_dat;
    logic [DATA_W-1:0] mem_dat;
    logic [DATA_W-1:0] pipe_dat;
    logic [DATA_W-1:0] pipe_src;
    logic pipe_dir;
    logic irq_n;
    logic [1:0] irq_cnt;
    ffc_tap_e tap;
    logic tck_prev;
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] ir;
    logic byp;
    logic tdo;
    logic parity;
  } ffc_state_s;

  ffc_state_s q, d;
  logic [DATA_W-1:0] conv;
  logic in_nan;
  logic nan_event;
  logic access;
  logic tck_rise;
  logic tck_fall;

  always_comb
  begin
    d = q;
    access = !drive_en_n_i;
    // one converter path chosen by the direction pin.
    conv = dir_i ? ffc_ieee_to_native(memory_side_bus_i) : ffc_native_to_ieee(host_side_bus_i);
    in_nan = memory_side_bus_i[IEEE_EXP_HI:IEEE_EXP_LO] == IEEE_EXP_SPECIAL
      && memory_side_bus_i[FRAC_HI:0] != 23'h000000;
    nan_event = 1'b0;
    d.extend = 1'b0;
    d.host_oe = access && dir_i;
    d.mem_oe = access && !dir_i;
    case (q.acc)
      A_IDLE:
      begin
        if (access)
        begin
          d.acc = A_WAIT;
          d.extend = !pipe_i;
        end
      end
      A_WAIT:
      begin
        d.acc = access ? A_HOLD : A_IDLE;
        nan_event = !pipe_i && dir_i && in_nan;
      end
      A_HOLD:
      begin
        if (!access)
          d.acc = A_IDLE;
      end
      default: d.acc = A_IDLE;
    endcase
    if (pipe_i)
    begin
      // Pipeline mode shows the previous access's result; the last input seen in an
      // access is converted when the access ends, so one extra access flushes it.
      d.host_dat = q.pipe_dat;
      d.mem_dat = q.pipe_dat;
      if (access)
      begin
        d.pipe_src = dir_i ? memory_side_bus_i : host_side_bus_i;
        d.pipe_dir = dir_i;
      end
      else if (q.acc != A_IDLE)
      begin
        d.pipe_dat = q.pipe_dir ? ffc_ieee_to_native(q.pipe_src)
                                : ffc_native_to_ieee(q.pipe_src);
        nan_event = q.pipe_dir && q.pipe_src[IEEE_EXP_HI:IEEE_EXP_LO] == IEEE_EXP_SPECIAL
          && q.pipe_src[FRAC_HI:0] != 23'h000000;
      end
    end
    else
    begin
      d.host_dat = conv;
      d.mem_dat = conv;
    end
    // A fresh event during a pulse is merged into it rather than stretching it.
    if (q.irq_cnt != 2'h0)
      d.irq_cnt = q.irq_cnt - 2'h1;
    else if (nan_event)
      d.irq_cnt = 2'(NAN_PULSE_CYCLES);
    d.irq_n = !(d.irq_cnt != 2'h0);
    // Test access port advanced on rising test clock, output changed on falling edge.
    tck_rise = tck_i && !q.tck_prev;
    tck_fall = !tck_i && q.tck_prev;
    d.tck_prev = tck_i;
    if (tck_rise)
    begin
      d.tap = ffc_tap_next(q.tap, tms_i);
      case (q.tap)
        T_TLR: d.ir = IR_RESET_VAL;
        T_CIR: d.ir_sh = IR_CAPTURE_VAL;
        T_SIR: d.ir_sh = {tdi_i, q.ir_sh[IR_W-1:1]};
        T_UIR: d.ir = q.ir_sh;
        T_CDR: d.byp = 1'b0;
        T_SDR: d.byp = tdi_i;
        default: d.byp = q.byp;
      endcase
    end
    if (tck_fall)
      d.tdo = (q.tap == T_SIR) ? q.ir_sh[0] : q.byp;
    d.parity = (q.tap == T_PIR) ? ^q.ir_sh : 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '{acc: A_IDLE, extend: 1'b0, host_oe: 1'b0, mem_oe: 1'b0,
             host_dat: 32'h00000000, mem_dat: 32'h00000000, pipe_dat: 32'h00000000,
             pipe_src: 32'h00000000, pipe_dir: 1'b0, irq_n: 1'b1, irq_cnt: 2'h0,
             tap: T_TLR, tck_prev: 1'b0, ir_sh: IR_RESET_VAL, ir: IR_RESET_VAL,
             byp: 1'b0, tdo: 1'b0, parity: 1'b0};
    end
    else
      q <= d;
  end

  assign access_extend_o = q.extend;
  assign invalid_number_irq_n_o = q.irq_n;
  assign host_side_bus_o = q.host_dat;
  assign host_side_bus_oe_o = q.host_oe;
  assign memory_side_bus_o = q.mem_dat;
  assign memory_side_bus_oe_o = q.mem_oe;
  assign tdo_o = q.tdo;
  assign scan_instruction_parity_o = q.parity;

  sequence s_irq_low2;
    !invalid_number_irq_n_o [*2];
  endsequence

  a_pipe_no_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    pipe_i |=> !access_extend_o)
    else $error("access extend raised in pipeline mode");
  a_wait_on_access: assert property (@(posedge clk_i) disable iff (rst_i)
    (q.acc == A_IDLE && !drive_en_n_i && !pipe_i) |=> access_extend_o)
    else $error("no wait state on a non-pipelined access");
  a_single_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    (access_extend_o && !drive_en_n_i) |=> !access_extend_o [*2])
    else $error("more than one wait state");
  a_bus_release: assert property (@(posedge clk_i) disable iff (rst_i)
    drive_en_n_i |=> !host_side_bus_oe_o && !memory_side_bus_oe_o)
    else $error("bus driven while drive enable is high");
  a_host_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    (!drive_en_n_i && dir_i && !pipe_i) |=> host_side_bus_oe_o && !memory_side_bus_oe_o
      && host_side_bus_o == ffc_ieee_to_native($past(memory_side_bus_i)))
    else $error("host side not driven with converted memory word");
  a_mem_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    (!drive_en_n_i && !dir_i && !pipe_i) |=> memory_side_bus_oe_o && !host_side_bus_oe_o
      && memory_side_bus_o == ffc_native_to_ieee($past(host_side_bus_i)))
    else $error("memory side not driven with converted host word");
  a_nan_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(invalid_number_irq_n_o) |-> s_irq_low2 ##1 invalid_number_irq_n_o)
    else $error("not-a-number pulse has wrong length");
  a_nan_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    (q.acc == A_WAIT && !pipe_i && dir_i && in_nan && q.irq_cnt == 2'h0)
      |=> !invalid_number_irq_n_o)
    else $error("not-a-number conversion raised no interrupt");
  a_ir_parity: assert property (@(posedge clk_i) disable iff (rst_i)
    (q.tap == T_PIR) |=> scan_instruction_parity_o == ^$past(q.ir_sh))
    else $error("instruction parity wrong in pause");
endmodule : ffc_top

// file: verification/ffc_mem_model.sv
/*
  Memory array model on the memory side of the converter.
  Assumes the bench resolves the shared memory bus from the model's and the converter's drive.
*/
`timescale 1ns/1ns
module ffc_mem_model (
  // Clock
  input wire logic clk_i,
  // Access control seen at the array
  input wire logic dir_i,
  input wire logic drive_en_n_i,
  // Array contents and bus
  input wire logic [31:0] word_i,
  input wire logic [31:0] bus_i,
  output logic [31:0] bus_o,
  output logic [31:0] stored_o
);
  logic [31:0] last_q = 32'h00000000;
  logic drive;
  assign drive = dir_i && !drive_en_n_i;
  // A released array shows the inverse of its last word, so stale data never reads as valid.
  assign bus_o = drive ? word_i : ~last_q;
  always @(posedge clk_i)
  begin
    if (drive)
      last_q <= word_i;
    if (!dir_i && !drive_en_n_i)
      stored_o <= bus_i;
  end
endmodule : ffc_mem_model

// file: verification/testbench.sv
/*
  Self-checking bench for the format converter: conversions, wait state, pipeline,
  interrupt, reset and scan parity. Assumes the memory model beside it.
*/
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0;
  logic rst, dir, en_n, pipe, tck, tms, tdi;
  logic [31:0] host_drv, mem_word, host_o, mem_o, mdl_o, stored, host_bus, mem_bus;
  logic host_oe, mem_oe, ext, irq_n, parity, tdo;
  int bad_count = 0;
  int cmp_count = 0;
  int ext_cnt = 0;
  int irq_cnt = 0;
  assign host_bus = host_oe ? host_o : host_drv;
  assign mem_bus = mem_oe ? mem_o : mdl_o;
  ffc_top u_dut (.clk_i(clk), .rst_i(rst), .dir_i(dir), .drive_en_n_i(en_n), .pipe_i(pipe),
    .access_extend_o(ext), .invalid_number_irq_n_o(irq_n), .host_side_bus_i(host_bus),
    .host_side_bus_o(host_o), .host_side_bus_oe_o(host_oe), .memory_side_bus_i(mem_bus),
    .memory_side_bus_o(mem_o), .memory_side_bus_oe_o(mem_oe), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .tdo_o(tdo), .scan_instruction_parity_o(parity));
  ffc_mem_model u_mem (.clk_i(clk), .dir_i(dir), .drive_en_n_i(en_n), .word_i(mem_word),
    .bus_i(mem_bus), .bus_o(mdl_o), .stored_o(stored));
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    ext_cnt <= ext_cnt + int'(ext === 1'b1);
    irq_cnt <= irq_cnt + int'(irq_n === 1'b0);
  end
  task automatic tally_and_finish;
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic chk_idle;
    check({27'h0, host_oe, mem_oe, ext, irq_n, parity}, 32'h00000002);
    check(host_o | mem_o, 32'h00000000);
  endtask : chk_idle
  task automatic xfer(input logic d, input logic [31:0] w, input logic [31:0] exp,
    input logic chk);
    dir <= d;
    en_n <= 1'b0;
    if (d)
      mem_word <= w;
    else
      host_drv <= w;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check({30'h0, host_oe, mem_oe}, {30'h0, d, !d});
    if (chk)
      check(d ? host_o : mem_o, exp);
    @(posedge clk);
    en_n <= 1'b1;
    host_drv <= ~host_drv;
  endtask : xfer
  task automatic np_case(input logic d, input logic [31:0] w, input logic [31:0] exp);
    int e0;
    int i0;
    logic is_invalid;
    e0 = ext_cnt;
    i0 = irq_cnt;
    is_invalid = d && w[30:23] == 8'hff && w[22:0] != 23'h000000;
    xfer(d, w, exp, 1'b1);
    repeat (3) @(posedge clk);
    @(negedge clk);
    check({30'h0, host_oe, mem_oe}, 32'h00000000);
    check(32'(ext_cnt - e0), 32'h00000001);
    check(32'(irq_cnt - i0), is_invalid ? 32'h00000002 : 32'h00000000);
    if (!d)
      check(stored, exp);
    @(posedge clk);
  endtask : np_case
  task automatic pipe_case;
    int e0;
    int i0;
    e0 = ext_cnt;
    i0 = irq_cnt;
    pipe <= 1'b1;
    @(posedge clk);
    xfer(1'b1, 32'h40000000, 32'h0, 1'b0);
    @(posedge clk);
    xfer(1'b1, 32'hbf800000, 32'h01000000, 1'b1);
    @(posedge clk);
    xfer(1'b1, 32'h7fc00000, 32'hff800000, 1'b1);
    @(posedge clk);
    xfer(1'b0, 32'h01400000, 32'h7f7fffff, 1'b1);
    @(posedge clk);
    xfer(1'b0, 32'h01400000, 32'h40400000, 1'b1);
    @(posedge clk);
    @(negedge clk);
    check(32'(ext_cnt - e0), 32'h00000000);
    check(32'(irq_cnt - i0), 32'h00000002);
    @(posedge clk);
    pipe <= 1'b0;
  endtask : pipe_case
  task automatic reset_case;
    dir <= 1'b1;
    en_n <= 1'b0;
    mem_word <= 32'h3f800000;
    repeat (2) @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk_idle();
    @(posedge clk);
    rst <= 1'b0;
    en_n <= 1'b1;
    @(posedge clk);
  endtask : reset_case
  task automatic tck_step(input logic m);
    tms <= m;
    tck <= 1'b0;
    repeat (3) @(posedge clk);
    tck <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : tck_step
  task automatic scan_case;
    logic [10:0] first;
    logic [3:0] second;
    first = 11'b11111011010;
    second = 4'b1010;
    for (int i = 10; i >= 0; i--)
      tck_step(first[i]);
    @(negedge clk);
    check({31'h0, parity}, 32'h00000001);
    @(posedge clk);
    // A zero shifted in clears the only set bit, so the parity must flip.
    tdi <= 1'b0;
    for (int i = 3; i >= 0; i--)
    begin
      tck_step(second[i]);
      if (i == 1)
      begin
        @(negedge clk);
        check({31'h0, tdo}, 32'h00000001);
        @(posedge clk);
      end
    end
    @(negedge clk);
    check({31'h0, parity}, 32'h00000000);
    @(posedge clk);
    tck_step(1'b1);
    @(negedge clk);
    check({31'h0, parity}, 32'h00000000);
  endtask : scan_case
  initial
  begin
    rst = 1'b1;
    en_n = 1'b1;
    dir = 1'b0;
    pipe = 1'b0;
    host_drv = 32'h0;
    mem_word = 32'h0;
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk_idle();
    @(posedge clk);
    np_case(1'b1, 32'h3f800000, 32'h00000000);
    np_case(1'b1, 32'hbf800000, 32'hff800000);
    np_case(1'b1, 32'hbfc00000, 32'h00c00000);
    np_case(1'b1, 32'h3fc00000, 32'h00400000);
    np_case(1'b1, 32'h00000000, 32'h80000000);
    np_case(1'b1, 32'h00400000, 32'h81000000);
    np_case(1'b1, 32'h00000001, 32'h80000000);
    np_case(1'b1, 32'h7fc00000, 32'h7f7fffff);
    np_case(1'b1, 32'h7f800000, 32'h7f7fffff);
    np_case(1'b0, 32'h00000000, 32'h3f800000);
    np_case(1'b0, 32'hff800000, 32'hbf800000);
    np_case(1'b0, 32'h80000000, 32'h00000000);
    np_case(1'b0, 32'h7fc00000, 32'hff400000);
    pipe_case();
    reset_case();
    scan_case();
    tally_and_finish();
  end
  // The run needs well under a thousand cycles; this limit only cuts a hang short.
  initial
  begin
    repeat (3000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
endmodule : testbench
